// ### scd_ctrl.sv
// Controller for a 256K x 4 static column memory: request port, refresh, pins.
// Assumes the memory's pins are wired straight; data pins resolved by the bench.
// Functional notes
// - Address sent as row then column halves
// - Write enable high reads, low writes
// - Never drive data while device outputs
// - Both strobes high end cycle, precharge
// - All 512 rows refreshed every 8 ms
// - Static column: row open, columns change
// - Static write: data per column, oe high
// - Row strobe low at most 10 us
// - Static column row low at most 100 us
// - Wait 100 us, then eight wake cycles
// - Column strobe high before row strobe falls; refresh cycles drop it first
module scd_ctrl
   import scd_pkg::*;
#(
   parameter int PWRUP_CYC = PWRUP_CYC_DEF,
   parameter int REFI_CYC  = REFI_CYC_DEF,
   parameter int MAX_BURST = 64
) (
   input  wire logic              mclk_i,
   input  wire logic              nrst_i,
   input  wire logic              req_valid_i,
   output logic                   req_ready_o,
   input  wire logic              req_write_i,
   input  wire logic              req_last_i,
   input  wire logic [ROW_W-1:0]  req_row_i,
   input  wire logic [COL_W-1:0]  req_col_i,
   input  wire logic [DATA_W-1:0] req_wdata_i,
   output logic                   rd_valid_o,
   output logic [DATA_W-1:0]      rd_data_o,
   output logic                   init_done_o,
   output logic                   ras_n_o,
   output logic                   cas_n_o,
   output logic                   we_n_o,
   output logic                   oe_n_o,
   output logic                   test_function_pin_o,
   output logic [ROW_W-1:0]       multiplexed_address_o,
   input  wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0]      dq_o,
   output logic                   dq_oe_o
);
   if (PWRUP_CYC < 1 || PWRUP_CYC >= (1 << CNT_W)) begin : g_bad_pwrup
      $error("scd_ctrl: bad PWRUP_CYC");
   end
   // A burst keeps the column strobe low throughout, so it must fit both limits
   if (MAX_BURST < 1 || MAX_BURST > 256 || MAX_BURST * (SC_CYC + 1) + 2 > RASMAX_CYC ||
       MAX_BURST * (SC_CYC + 1) + RCD_CYC + 3 > RASCMAX_CYC) begin : g_bad_burst
      $error("scd_ctrl: MAX_BURST breaks the strobe low limits");
   end
   if (RAS_CYC + CPN_CYC > RASMAX_CYC) begin : g_bad_timing
      $error("scd_ctrl: timing");
   end
   typedef enum logic [3:0] {
      S_PWRUP, S_IDLE, S_RAS, S_CAS, S_COL, S_NEXT, S_PRE, S_CBR_CAS, S_CBR_RAS
   } scd_state_t;
   typedef struct packed {
      scd_state_t        state;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  ras_cnt;
      logic [3:0]        wake;
      logic [7:0]        burst;
      logic              pend_ref;
      logic              init_done;
      logic              wr;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic              oe_n;
      logic [ROW_W-1:0]  addr;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
      logic [DATA_W-1:0] wdata;
      logic              dq_oe;
      logic [DATA_W-1:0] dq_s1;
      logic [DATA_W-1:0] dq_s2;
      logic              rd_valid;
      logic [DATA_W-1:0] rd_data;
   } scd_ctrl_t;
   scd_ctrl_t st, next_st;
   logic      ref_tick;
   logic      take;
   logic      cont;
   localparam scd_ctrl_t ST_RST = '{state: S_PWRUP, cnt: CNT_W'(PWRUP_CYC), ras_n: 1'b1, cas_n: 1'b1,
                                    we_n: 1'b1, oe_n: 1'b1, default: '0};

   // One refresh every 15 us keeps 512 rows inside 8 ms
   scd_tick #(.PERIOD(REFI_CYC)) u_tick (
      .mclk_i (mclk_i),
      .nrst_i (nrst_i),
      .tick_o (ref_tick)
   );

   assign take = (st.state == S_IDLE) && st.init_done && !st.pend_ref && req_valid_i;
   // Only a same-row, same-kind access may extend an open row
   assign cont = (st.state == S_NEXT) && !st.pend_ref && req_valid_i && req_write_i == st.wr &&
                 req_row_i == st.row && st.burst != 8'(MAX_BURST - 1);
   assign req_ready_o = take || cont;

   always_comb begin
      next_st          = st;
      next_st.dq_s1    = dq_i;
      next_st.dq_s2    = st.dq_s1;
      next_st.rd_valid = 1'b0;
      next_st.ras_cnt  = st.ras_n ? '0 : st.ras_cnt + 1'b1;
      if (ref_tick) next_st.pend_ref = 1'b1;
      if (st.cnt != '0) next_st.cnt = st.cnt - 1'b1;
      unique case (st.state)
         S_PWRUP: begin
            if (st.cnt == '0) begin
               next_st.state = S_CBR_CAS;
               next_st.cas_n = 1'b0;
               next_st.cnt   = CNT_W'(CPN_CYC);
            end
         end
         S_IDLE: begin
            if (st.pend_ref || !st.init_done) begin
               next_st.state = S_CBR_CAS;
               next_st.cas_n = 1'b0;
               next_st.cnt   = CNT_W'(CPN_CYC);
            end else if (req_valid_i) begin
               next_st.state = S_RAS;
               next_st.ras_n = 1'b0;
               next_st.addr  = req_row_i;
               next_st.row   = req_row_i;
               next_st.wr    = req_write_i;
               next_st.we_n  = !req_write_i;
               next_st.col   = req_col_i;
               next_st.wdata = req_wdata_i;
               next_st.dq_oe = req_write_i;
               next_st.burst = req_last_i ? 8'(MAX_BURST - 1) : 8'h00;
               next_st.cnt   = CNT_W'(RCD_CYC);
            end
         end
         S_RAS: begin
            if (st.cnt == '0) begin
               next_st.addr  = st.col;
               next_st.cas_n = 1'b0;
               next_st.oe_n  = st.wr;
               next_st.dq_oe = st.wr;
               next_st.state = S_CAS;
               next_st.cnt   = CNT_W'(CAS_CYC > SC_CYC ? CAS_CYC : SC_CYC);
            end
         end
         S_CAS, S_COL: begin
            if (st.cnt == '0) begin
               if (!st.wr) begin
                  next_st.rd_valid = 1'b1;
                  next_st.rd_data  = st.dq_s2;
               end
               next_st.state = S_NEXT;
            end
         end
         S_NEXT: begin
            if (cont) begin
               next_st.addr  = req_col_i;
               next_st.wdata = req_wdata_i;
               next_st.burst = req_last_i ? 8'(MAX_BURST - 1) : st.burst + 1'b1;
               next_st.state = S_COL;
               next_st.cnt   = CNT_W'(SC_CYC);
            end else begin
               next_st.ras_n = 1'b1;
               next_st.cas_n = 1'b1;
               next_st.oe_n  = 1'b1;
               next_st.we_n  = 1'b1;
               next_st.dq_oe = 1'b0;
               next_st.state = S_PRE;
               next_st.cnt   = CNT_W'(RP_CYC);
            end
         end
         S_CBR_CAS: begin
            if (st.cnt == '0) begin
               next_st.ras_n = 1'b0;
               next_st.state = S_CBR_RAS;
               next_st.cnt   = CNT_W'(RAS_CYC);
               next_st.pend_ref = ref_tick;
            end
         end
         S_CBR_RAS: begin
            if (st.cnt == '0) begin
               next_st.ras_n = 1'b1;
               next_st.cas_n = 1'b1;
               next_st.state = S_PRE;
               next_st.cnt   = CNT_W'(RP_CYC);
               if (!st.init_done) begin
                  next_st.wake = st.wake + 1'b1;
                  if (st.wake == 4'(WAKE_CYCLES - 1)) next_st.init_done = 1'b1;
               end
            end
         end
         S_PRE: begin
            if (st.cnt == '0) next_st.state = S_IDLE;
         end
         default: next_st.state = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   assign ras_n_o               = st.ras_n;
   assign cas_n_o               = st.cas_n;
   assign we_n_o                = st.we_n;
   assign oe_n_o                = st.oe_n;
   assign test_function_pin_o   = 1'b0;
   assign multiplexed_address_o = st.addr;
   assign dq_o                  = st.wdata;
   assign dq_oe_o               = st.dq_oe;
   assign rd_valid_o            = st.rd_valid;
   assign rd_data_o             = st.rd_data;
   assign init_done_o           = st.init_done;

   no_bus_clash_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      dq_oe_o |-> oe_n_o && !we_n_o) else $error("data driven while device may drive");
   ras_low_limit_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      st.ras_cnt < CNT_W'(RASCMAX_CYC)) else $error("row strobe low too long");
   cbr_order_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $fell(ras_n_o) && !cas_n_o |-> $past(cas_n_o, CPN_CYC + 2) && st.state == S_CBR_RAS)
      else $error("row fell with column low outside refresh");
   read_oe_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !oe_n_o |-> we_n_o && !cas_n_o) else $error("output enable in write");
   test_low_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !test_function_pin_o) else $error("test pin raised");
   no_early_use_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !init_done_o |-> !req_ready_o) else $error("request taken before wake-up");
   precharge_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(ras_n_o) |-> ras_n_o [*8]) else $error("precharge too short");
   rcd_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $fell(ras_n_o) && cas_n_o |-> cas_n_o [*6]) else $error("column strobe too early");
endmodule : scd_ctrl

// ### scd_mem_model.sv
// Behavioural 256K x 4 static column memory at the controller's pins.
// Assumes the bench resolves the shared data pins from both drivers.
module scd_mem_model
   import scd_pkg::*;
(
   input  wire logic              ras_n_i,
   input  wire logic              cas_n_i,
   input  wire logic              we_n_i,
   input  wire logic              oe_n_i,
   input  wire logic              tf_i,
   input  wire logic [ROW_W-1:0]  addr_i,
   input  wire logic [DATA_W-1:0] din_i,
   output logic [DATA_W-1:0]      dout_o,
   output logic                   drv_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [bit [ROW_W+COL_W-1:0]];
   logic [ROW_W-1:0]  row = '0;
   logic              held = 1'b0;
   int                cbr_cnt = 0;
   // Column strobe low at row fall means refresh from the internal counter
   always @(negedge ras_n_i) begin
      #1;
      if (cas_n_i) row = addr_i;
      else cbr_cnt++;
   end
   always @(negedge we_n_i) if (drv_o && !cas_n_i) held = 1'b1;
   always @(posedge cas_n_i) held = 1'b0;
   // Writes settle 1 ns after a pin change, so a closing edge stores nothing
   always @(ras_n_i, cas_n_i, we_n_i, addr_i, din_i) begin
      #1;
      if (!ras_n_i && !cas_n_i && !we_n_i) mem[{row, addr_i}] = din_i;
   end
   always @* begin
      drv_o = (!ras_n_i && !cas_n_i && !oe_n_i && (we_n_i || held))
              || (!ras_n_i && !cas_n_i && we_n_i && oe_n_i && tf_i);
      dout_o = mem.exists({row, addr_i}) ? mem[{row, addr_i}] : 4'h0;
   end
endmodule : scd_mem_model

// ### scd_pkg.sv
// Constants for the static column memory port controller.
// Assumes a 125 MHz controller clock; all pin timing is counted in its cycles.
package scd_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int ROW_W         = 9;
   localparam int COL_W         = 9;
   localparam int DATA_W        = 4;
   localparam int ROW_COUNT     = 512;
   // Least times round up, longest round down
   localparam int T_RP_NS       = 100;
   localparam int T_RAS_MIN_NS  = 150;
   localparam int T_RCD_NS      = 45;
   localparam int T_CAS_NS      = 45;
   localparam int T_CPN_NS      = 25;
   localparam int T_SC_NS       = 75;
   localparam int T_RAS_MAX_NS  = 10000;
   localparam int T_RASC_MAX_NS = 100000;
   localparam int T_REF_MS      = 8;
   localparam int T_PWRUP_US    = 100;
   localparam int T_REFI_US     = 15;
   localparam int WAKE_CYCLES   = 8;
   localparam int RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAS_CYC  = (T_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RCD_CYC  = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAS_CYC  = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CPN_CYC  = (T_CPN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SC_CYC   = (T_SC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RASMAX_CYC  = T_RAS_MAX_NS / CLK_PERIOD_NS;
   localparam int RASCMAX_CYC = T_RASC_MAX_NS / CLK_PERIOD_NS;
   localparam int PWRUP_CYC_DEF = T_PWRUP_US * 1000 / CLK_PERIOD_NS;
   localparam int REFI_CYC_DEF  = T_REFI_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
endpackage : scd_pkg

// ### scd_tick.sv
// Free running down counter that pulses once every PERIOD cycles.
// Assumes a single clock domain shared with the controller.
module scd_tick
   import scd_pkg::*;
#(
   parameter int PERIOD = 1875
) (
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   output logic      tick_o
);
   if (PERIOD < 2 || PERIOD >= (1 << CNT_W)) begin : g_bad_period
      $error("scd_tick: bad PERIOD");
   end
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } scd_tick_t;
   scd_tick_t st, next_st;
   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (st.cnt == '0) begin
         next_st.cnt  = CNT_W'(PERIOD - 1);
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) st <= '{cnt: '0, tick: 1'b0};
      else         st <= next_st;
   end
   assign tick_o = st.tick;
endmodule : scd_tick

// ### tb.sv
// Bench for the static column controller with a behavioural memory.
// Assumes shortened power-up and refresh intervals to keep the run brief.
module tb
   import scd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk_i = 1'b0;
   logic              nrst_i = 1'b0;
   logic              req_valid_i = 1'b0, req_write_i = 1'b0, req_last_i = 1'b0;
   logic [ROW_W-1:0]  req_row_i = '0, req_col_i = '0, addr;
   logic [DATA_W-1:0] req_wdata_i = '0, rd_data_o, dq_o, m_dq, idle = 4'h5;
   logic              req_ready_o, rd_valid_o, init_done_o, ras_n_o, cas_n_o;
   logic              we_n_o, oe_n_o, tf_o, dq_oe_o, m_drv;
   wire  [DATA_W-1:0] bus = m_drv ? m_dq : (dq_oe_o ? dq_o : idle);
   logic [DATA_W-1:0] got [$];
   int                error_cnt = 0, checked = 0, row_cnt = 0, hi_run = 0;

   scd_ctrl #(.PWRUP_CYC(20), .REFI_CYC(200), .MAX_BURST(64)) u_dut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_write_i(req_write_i), .req_last_i(req_last_i), .req_row_i(req_row_i),
      .req_col_i(req_col_i), .req_wdata_i(req_wdata_i), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .init_done_o(init_done_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o),
      .we_n_o(we_n_o), .oe_n_o(oe_n_o), .test_function_pin_o(tf_o),
      .multiplexed_address_o(addr), .dq_i(bus), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
   scd_mem_model u_mem (.ras_n_i(ras_n_o), .cas_n_i(cas_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o),
      .tf_i(tf_o), .addr_i(addr), .din_i(bus), .dout_o(m_dq), .drv_o(m_drv));

   always #4 mclk_i = ~mclk_i;
   // Released data pins show the inverse of the last level
   always @(posedge mclk_i) if (!$isunknown(bus)) idle <= ~bus;
   always @(negedge mclk_i) if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
   always @(negedge ras_n_o) if (cas_n_o === 1'b1) row_cnt++;
   always @(posedge mclk_i) if (nrst_i && dq_oe_o === 1'b1 && m_drv === 1'b1) fail("pin contention");
   always @(posedge mclk_i) begin
      if (ras_n_o === 1'b1) hi_run <= hi_run + 1;
      else begin
         if (nrst_i && hi_run > 0 && hi_run < RP_CYC) fail("short precharge");
         hi_run <= 0;
      end
   end

   task automatic fail(input string msg);
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
   endtask : fail
   task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string msg);
      checked++;
      if (g !== e) fail(msg);
   endtask : chk
   task automatic chk_n(input int g, input int e, input string msg);
      checked++;
      if (g != e) fail(msg);
   endtask : chk_n
   task automatic close_out();
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // Entered at a rising edge; returns at the edge that takes the request
   task automatic req(input logic w, input logic l, input logic [ROW_W-1:0] r,
                      input logic [COL_W-1:0] c, input logic [DATA_W-1:0] d);
      int i;
      req_valid_i <= 1'b1;
      req_write_i <= w;
      req_last_i  <= l;
      req_row_i   <= r;
      req_col_i   <= c;
      req_wdata_i <= d;
      for (i = 0; i < 3000; i++) begin
         @(negedge mclk_i);
         if (req_ready_o === 1'b1) break;
      end
      if (i == 3000) begin
         fail("request not taken");
         close_out();
      end
      @(posedge mclk_i);
   endtask : req
   task automatic rd_chk(input logic [DATA_W-1:0] e);
      int i;
      for (i = 0; i < 300 && got.size() == 0; i++) @(negedge mclk_i);
      if (got.size() == 0) begin
         fail("no read data");
         close_out();
      end
      chk(got.pop_front(), e, "read data");
   endtask : rd_chk

   task automatic t_init();
      int i;
      for (i = 0; i < 3000 && init_done_o !== 1'b1; i++) @(negedge mclk_i);
      chk_n(i < 3000, 1, "init timeout");
      chk_n(u_mem.cbr_cnt >= WAKE_CYCLES, 1, "wake cycles");
      chk({3'h0, tf_o}, 4'h0, "test pin");
      $display("t_init done");
   endtask : t_init
   task automatic t_single();
      @(posedge mclk_i);
      req(1'b1, 1'b1, 9'h1A5, 9'h03C, 4'hA);
      req(1'b1, 1'b1, 9'h05A, 9'h03C, 4'h5);
      req(1'b0, 1'b1, 9'h1A5, 9'h03C, 4'h0);
      req(1'b0, 1'b1, 9'h05A, 9'h03C, 4'h0);
      req_valid_i <= 1'b0;
      rd_chk(4'hA);
      rd_chk(4'h5);
      $display("t_single done");
   endtask : t_single
   task automatic t_burst();
      int i, n0, r0;
      n0 = u_mem.cbr_cnt;
      for (i = 0; i < 300 && u_mem.cbr_cnt == n0; i++) @(negedge mclk_i);
      chk_n(u_mem.cbr_cnt - n0, 1, "refresh interval");
      r0 = row_cnt;
      @(posedge mclk_i);
      for (i = 0; i < 4; i++) req(1'b1, i == 3, 9'h0F0, 9'h1FC + 9'(i), 4'(i + 3));
      for (i = 0; i < 4; i++) req(1'b0, i == 3, 9'h0F0, 9'h1FC + 9'(i), 4'h0);
      req_valid_i <= 1'b0;
      for (i = 0; i < 4; i++) rd_chk(4'(i + 3));
      chk_n(row_cnt - r0, 2, "row opens");
      $display("t_burst done");
   endtask : t_burst

   initial begin
      repeat (6) @(posedge mclk_i);
      chk({2'h0, ras_n_o & cas_n_o, dq_oe_o}, 4'h2, "reset pins");
      nrst_i <= 1'b1;
      t_init();
      t_single();
      t_burst();
      close_out();
   end
endmodule : tb
